// file: rmd_rmii_phy.sv
// phy-side reduced media independent data path: transmit di-bit capture,
// receive carrier detection, nibble buffer and carrier-sense/data-valid sequencing
// assumes the pcs delivers decoded nibbles and line bits synchronous to clk_i
`timescale 1ns/1ns
module rmd_rmii_phy
(
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    input  wire logic             speed_100_i,
    input  wire logic             transmit_enable_pin_i,
    input  wire logic [1:0]       txd_i,
    input  wire logic             squelch_i,
    input  wire logic             line_bit_i,
    input  wire logic             line_bit_en_i,
    input  wire logic             line_idle_i,
    input  wire logic             false_carrier_i,
    input  wire rmd_pkg::rmd_nib_s rx_nib_i,
    input  wire logic             rx_nib_valid_i,
    output logic                  carrier_valid_pin_o,
    output logic [1:0]            rxd_o,
    output logic                  receive_error_pin_o,
    output logic [1:0]            tx_dibit_o,
    output logic                  tx_dibit_valid_o,
    output logic                  tx_active_o
);
    import rmd_pkg::*;

    rmd_regs_s s_r;
    rmd_regs_s s_nxt;
    logic      step;
    logic      hit100;
    logic      car_sync;
    logic      loading;
    logic      wr;

    // two zeros with at least one bit between them inside the window
    function automatic logic nc_zeros(input logic [RMD_WIN_BITS-1:0] w);
        logic r;
        r = 1'b0;
        for (int i = 0; i < RMD_WIN_BITS; i++)
        begin
            for (int j = i + 2; j < RMD_WIN_BITS; j++)
            begin
                if (!w[i] && !w[j])
                begin
                    r = 1'b1;
                end
            end
        end
        return r;
    endfunction

    // one clock, slow rate as enable
    assign step     = speed_100_i || (s_r.cnt == RMD_CNT_LAST);
    assign hit100   = line_bit_en_i && nc_zeros({s_r.win[RMD_WIN_BITS-2:0], line_bit_i});
    // decisions use the synchronised carrier; the raw level bridges
    // the two cycles before the synchroniser sees a fresh squelch
    assign car_sync = speed_100_i ? s_r.car100 : (s_r.sq_s2 || squelch_i);
    assign wr       = rx_nib_valid_i && (s_r.fill != RMD_CNT_FULL);

    always_comb
    begin
        s_nxt   = s_r;
        loading = 1'b0;
        s_nxt.cnt   = (step || speed_100_i) ? RMD_CNT_ZERO : s_r.cnt + 4'h1;
        s_nxt.sq_s1 = squelch_i;
        s_nxt.sq_s2 = s_r.sq_s1;
        if (line_bit_en_i)
        begin
            s_nxt.win = {s_r.win[RMD_WIN_BITS-2:0], line_bit_i};
        end
        if (hit100)
        begin
            s_nxt.car100 = 1'b1;
        end
        else if (line_idle_i)
        begin
            s_nxt.car100 = 1'b0;
        end

        // accept di-bit while enabled, ignore otherwise, one per slow step
        s_nxt.txv   = transmit_enable_pin_i && step;
        s_nxt.txd   = (transmit_enable_pin_i && step) ? txd_i : RMD_IDLE_DIBIT;
        s_nxt.txact = transmit_enable_pin_i;

        // di-bit sequencing, low di-bit first; nothing before a nibble exists
        if (step)
        begin
            if (s_r.pres && !s_r.sel)
            begin
                s_nxt.sel = 1'b1;
                s_nxt.rxd = s_r.cur.nib[3:2];
            end
            else if (s_r.fill != '0 && s_r.st != RMD_ST_FALSE && s_r.st != RMD_ST_IDLE)
            begin
                loading    = 1'b1;
                s_nxt.pres = 1'b1;
                s_nxt.sel  = 1'b0;
                s_nxt.cur  = rmd_nib_s'(s_r.mem[s_r.rp]);
                s_nxt.rxd  = s_nxt.cur.nib[1:0];
                s_nxt.rp   = s_r.rp + 2'h1;
            end
            else
            begin
                // idle di-bit when nothing to present
                s_nxt.pres = 1'b0;
                s_nxt.sel  = 1'b0;
                s_nxt.rxd  = RMD_IDLE_DIBIT;
            end
            // error shown with the nibble that carries it
            s_nxt.receive_error_pin = s_nxt.pres && s_nxt.cur.err;
        end

        case (s_r.st)
            RMD_ST_IDLE:
            begin
                // raw detection feeds the output flop directly for low latency
                if (speed_100_i ? (hit100 || s_r.car100) : squelch_i)
                begin
                    s_nxt.crs = 1'b1;
                    s_nxt.st  = RMD_ST_CARR;
                end
            end
            RMD_ST_CARR:
            begin
                if (false_carrier_i)
                begin
                    s_nxt.st = RMD_ST_FALSE;
                end
                else if (!car_sync && step && !s_nxt.sel)
                begin
                    s_nxt.crs = 1'b0;
                    s_nxt.st  = s_nxt.pres ? RMD_ST_DRAIN : RMD_ST_IDLE;
                end
            end
            RMD_ST_DRAIN:
            begin
                if (step)
                begin
                    s_nxt.crs = s_nxt.pres && s_nxt.sel;
                    if (!s_nxt.pres)
                    begin
                        s_nxt.st = RMD_ST_IDLE;
                    end
                end
            end
            RMD_ST_FALSE:
            begin
                // no toggling; buffer content of a false event is discarded
                if (!car_sync)
                begin
                    s_nxt.crs = 1'b0;
                    s_nxt.st  = RMD_ST_IDLE;
                end
            end
            default:
            begin
                s_nxt.st = RMD_ST_IDLE;
            end
        endcase

        if (s_r.st == RMD_ST_FALSE)
        begin
            s_nxt.rp   = s_r.wp;
            s_nxt.fill = '0;
            s_nxt.pres = 1'b0;
            s_nxt.rxd  = RMD_IDLE_DIBIT;
            s_nxt.receive_error_pin = 1'b0;
        end
        else
        begin
            if (wr)
            begin
                s_nxt.mem[s_r.wp] = rx_nib_i;
                s_nxt.wp          = s_r.wp + 2'h1;
            end
            s_nxt.fill = s_r.fill + {2'h0, wr} - {2'h0, loading};
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (rst_i)
        begin
            s_r       <= '0;
            s_r.st    <= RMD_ST_IDLE;
            s_r.win   <= RMD_WIN_IDLE;
            s_r.cnt   <= RMD_CNT_ZERO;
        end
        else
        begin
            s_r <= s_nxt;
        end
    end

    // every pin from a flop on clk_i
    assign carrier_valid_pin_o = s_r.crs;
    assign rxd_o               = s_r.rxd;
    assign receive_error_pin_o = s_r.receive_error_pin;
    assign tx_dibit_o          = s_r.txd;
    assign tx_dibit_valid_o    = s_r.txv;
    assign tx_active_o         = s_r.txact;

    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    chk_idle_rxd_zero: assert property (s_r.st == RMD_ST_IDLE |-> rxd_o == RMD_IDLE_DIBIT)
        else $error("receive data not idle while idle");
    chk_crs_fast_rise: assert property (s_r.st == RMD_ST_IDLE && !speed_100_i && squelch_i
        |=> carrier_valid_pin_o)
        else $error("carrier valid late");
    chk_tx_ignore_idle: assert property (!transmit_enable_pin_i
        |=> !tx_dibit_valid_o && tx_dibit_o == RMD_IDLE_DIBIT)
        else $error("transmit data taken while disabled");
    chk_tx_accept_fast: assert property (transmit_enable_pin_i && speed_100_i
        |=> tx_dibit_valid_o && tx_dibit_o == $past(txd_i))
        else $error("transmit di-bit not accepted");
    chk_crs_fall_nibble: assert property ($fell(carrier_valid_pin_o) && s_r.st == RMD_ST_DRAIN
        |-> !s_r.sel)
        else $error("carrier valid dropped mid nibble");
    chk_drain_toggle: assert property (s_r.st == RMD_ST_DRAIN && s_r.pres
        |-> carrier_valid_pin_o == s_r.sel)
        else $error("carrier valid not toggling with nibble phase");
    chk_false_hold: assert property (s_r.st == RMD_ST_FALSE |-> carrier_valid_pin_o)
        else $error("carrier valid dropped during false carrier");
    chk_slow_hold: assert property (!step && s_r.st != RMD_ST_FALSE |=> $stable(rxd_o))
        else $error("receive di-bit changed between steps");
    chk_pre_decode_zero: assert property (carrier_valid_pin_o && !s_r.pres
        |-> rxd_o == RMD_IDLE_DIBIT)
        else $error("receive data before decoding");
    chk_err_with_data: assert property (receive_error_pin_o |-> s_r.pres)
        else $error("receive error outside data");

    cov_drain: cover property (s_r.st == RMD_ST_DRAIN ##1 s_r.st == RMD_ST_IDLE);
    cov_false: cover property (s_r.st == RMD_ST_FALSE ##1 s_r.st == RMD_ST_IDLE);
    cov_tx_frame: cover property (tx_dibit_valid_o [*4]);
    cov_slow_rx: cover property (!speed_100_i && s_r.pres && carrier_valid_pin_o);
endmodule

// file: rmd_pkg.sv
// shared types and constants of the reduced media independent data interface
// assumes one reference clock; every slower rate comes from an enable pulse
package rmd_pkg;
    localparam int unsigned RMD_SLOW_DIV   = 10;
    localparam int unsigned RMD_CNT_W      = 4;
    localparam int unsigned RMD_WIN_BITS   = 10;
    localparam int unsigned RMD_FIFO_DEPTH = 4;
    localparam int unsigned RMD_PTR_W      = 2;
    localparam logic [1:0]  RMD_IDLE_DIBIT = 2'h0;
    localparam logic [RMD_CNT_W-1:0] RMD_CNT_LAST = 4'h9;
    localparam logic [RMD_CNT_W-1:0] RMD_CNT_ZERO = 4'h0;
    localparam logic [RMD_PTR_W:0]   RMD_CNT_FULL = 3'h4;
    localparam logic [RMD_WIN_BITS-1:0] RMD_WIN_IDLE = 10'h3ff;

    typedef enum logic [3:0] {
        RMD_ST_IDLE  = 4'h1,
        RMD_ST_CARR  = 4'h2,
        RMD_ST_DRAIN = 4'h4,
        RMD_ST_FALSE = 4'h8
    } rmd_state_e;

    // one received nibble with its error flag
    typedef struct packed {
        logic       err;
        logic [3:0] nib;
    } rmd_nib_s;

    typedef struct packed {
        rmd_state_e                         st;
        logic [RMD_CNT_W-1:0]               cnt;
        logic                               sq_s1;
        logic                               sq_s2;
        logic [RMD_WIN_BITS-1:0]            win;
        logic                               car100;
        logic [RMD_FIFO_DEPTH-1:0][4:0]     mem;
        logic [RMD_PTR_W-1:0]               wp;
        logic [RMD_PTR_W-1:0]               rp;
        logic [RMD_PTR_W:0]                 fill;
        logic                               pres;
        logic                               sel;
        rmd_nib_s                           cur;
        logic                               crs;
        logic [1:0]                         rxd;
        logic                               receive_error_pin;
        logic [1:0]                         txd;
        logic                               txv;
        logic                               txact;
    } rmd_regs_s;
endpackage

// file: rmd_mac_model.sv
// mac-side partner model: drives transmit enable and transmit di-bits
// assumes callers change signals just after a rising reference edge
`timescale 1ns/1ns
module rmd_mac_model
(
    output logic       tx_en_o,
    output logic [1:0] txd_o
);
    import rmd_pkg::*;

    initial
    begin
        tx_en_o = 1'b0;
        txd_o   = RMD_IDLE_DIBIT;
    end

    // enable framed on edges, idle 00 unless stray data is asked for
    task automatic drive(input logic en, input logic [1:0] d, input logic stray);
        tx_en_o = en;
        txd_o   = (en || stray) ? d : RMD_IDLE_DIBIT;
    endtask
endmodule

// file: tb.sv
// self-checking bench for the phy-side reduced data interface block
// assumes rmd_pkg, the design and the mac partner model are compiled first
`timescale 1ns/1ns
module tb;
    import rmd_pkg::*;
    logic       clk_i, rst_i, speed_100_i, squelch_i, line_bit_i, line_bit_en_i;
    logic       line_idle_i, false_carrier_i, rx_nib_valid_i, tx_en, crs, receive_error_pin, txv, txa;
    logic [1:0] txd, rxd, txo;
    rmd_nib_s   rx_nib_i;
    int         miscompares, n_tests, cyc;

    rmd_mac_model mac (.tx_en_o(tx_en), .txd_o(txd));
    rmd_rmii_phy dut (.clk_i(clk_i), .rst_i(rst_i), .speed_100_i(speed_100_i),
        .transmit_enable_pin_i(tx_en), .txd_i(txd), .squelch_i(squelch_i), .line_bit_i(line_bit_i),
        .line_bit_en_i(line_bit_en_i), .line_idle_i(line_idle_i), .false_carrier_i(false_carrier_i),
        .rx_nib_i(rx_nib_i), .rx_nib_valid_i(rx_nib_valid_i), .carrier_valid_pin_o(crs), .rxd_o(rxd),
        .receive_error_pin_o(receive_error_pin), .tx_dibit_o(txo), .tx_dibit_valid_o(txv), .tx_active_o(txa));

    initial
    begin
        clk_i = 1'b0;
        forever #50 clk_i = ~clk_i;
    end

    task automatic complete_run;
        $display("comparisons %0d miscompares %0d", n_tests, miscompares);
        if (miscompares == 0 && n_tests > 0)
            $display("RESULT: PASS");
        else
            $display("RESULT: FAIL");
        $finish;
    endtask

    // hang guard, runs need a few hundred cycles
    always @(posedge clk_i)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            miscompares++;
            complete_run();
        end
    end

    task automatic check(input logic [3:0] seen, input logic [3:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("Error at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    task automatic tick(input int n);
        repeat (n) @(posedge clk_i);
        #1;
    endtask

    task automatic wait_crs(input logic v, input int lim);
        for (int i = 0; i < lim && crs !== v; i++)
            tick(1);
    endtask

    task automatic carrier100;
        line_bit_en_i = 1'b1;
        // two zeros with a one between them
        for (int i = 0; i < 3; i++)
        begin
            line_bit_i = 1'(3'b010 >> i);
            tick(1);
        end
        line_bit_en_i = 1'b0;
        wait_crs(1'b1, 6);
    endtask

    task automatic end_carrier;
        line_idle_i = 1'b1;
        tick(1);
        line_idle_i = 1'b0;
    endtask

    task automatic t_tx100;
        for (int i = 0; i < 4; i++)
        begin
            mac.drive(1'b1, 2'(i + 1), 1'b0);
            tick(1);
            check({txa, txv, txo}, {2'h3, 2'(i + 1)});
        end
        mac.drive(1'b0, 2'h3, 1'b1);
        tick(1);
        check({txa, txv, txo}, 4'h0);
        tick(1);
        check({1'b0, txv, txo}, 4'h0);
        $display("tx 100 done");
    endtask

    task automatic t_tx10;
        int c;
        c = 0;
        speed_100_i = 1'b0;
        mac.drive(1'b1, 2'h2, 1'b0);
        for (int i = 0; i < 20; i++)
        begin
            tick(1);
            c += int'(txv === 1'b1 && txo === 2'h2);
        end
        check(4'(c), 4'h2);
        mac.drive(1'b0, 2'h0, 1'b0);
        tick(12);
        speed_100_i = 1'b1;
        $display("tx 10 done");
    endtask

    task automatic t_rx100;
        carrier100();
        check({1'b0, crs, rxd}, 4'h4);
        rx_nib_i = '{1'b1, 4'h6};
        rx_nib_valid_i = 1'b1;
        tick(1);
        rx_nib_valid_i = 1'b0;
        for (int i = 0; i < 8 && rxd === 2'h0; i++)
            tick(1);
        check({crs, receive_error_pin, rxd}, 4'he);
        tick(1);
        check({crs, receive_error_pin, rxd}, 4'hd);
        end_carrier();
        wait_crs(1'b0, 12);
        tick(2);
        check({1'b0, crs, rxd}, 4'h0);
        $display("rx 100 done");
    endtask

    task automatic t_drain;
        int          k, dr;
        logic        fell;
        logic [15:0] nibs;
        {k, dr, fell, nibs} = {32'h0, 32'h0, 1'b0, 16'hdbe7};
        carrier100();
        fork
            for (int i = 0; i < 30; i++)
            begin
                tick(1);
                fell |= (crs === 1'b0);
                if (rxd !== 2'h0)
                begin
                    // low di-bit shows crs low once carrier went, high di-bit crs high
                    check({1'b0, crs, rxd}, {1'b0, !fell || k[0], nibs[2*k +: 2]});
                    dr += int'(fell);
                    k++;
                end
            end
            begin
                for (int i = 0; i < 4; i++)
                begin
                    rx_nib_i = '{1'b0, nibs[4*i +: 4]};
                    rx_nib_valid_i = 1'b1;
                    tick(1);
                end
                rx_nib_valid_i = 1'b0;
                end_carrier();
            end
        join
        check(4'(k), 4'h8);
        check(4'(dr > 0), 4'h1);
        $display("drain done");
    endtask

    task automatic t_false;
        carrier100();
        false_carrier_i = 1'b1;
        tick(1);
        false_carrier_i = 1'b0;
        rx_nib_i = '{1'b0, 4'h5};
        rx_nib_valid_i = 1'b1;
        for (int i = 0; i < 10; i++)
        begin
            tick(1);
            rx_nib_valid_i = 1'b0;
            check({1'b0, crs, rxd}, 4'h4);
        end
        end_carrier();
        wait_crs(1'b0, 12);
        for (int i = 0; i < 10; i++)
        begin
            check({3'h0, crs}, 4'h0);
            tick(1);
        end
        $display("false carrier done");
    endtask

    task automatic t_rx10;
        int c;
        c = 0;
        speed_100_i = 1'b0;
        squelch_i = 1'b1;
        wait_crs(1'b1, 30);
        check({1'b0, crs, rxd}, 4'h4);
        rx_nib_i = '{1'b0, 4'h6};
        rx_nib_valid_i = 1'b1;
        tick(1);
        rx_nib_valid_i = 1'b0;
        for (int i = 0; i < 40 && rxd === 2'h0; i++)
            tick(1);
        for (; c < 20 && rxd === 2'h2; c++)
            tick(1);
        check(4'(c), 4'ha);
        check({2'h0, rxd}, 4'h1);
        squelch_i = 1'b0;
        wait_crs(1'b0, 60);
        check({3'h0, crs}, 4'h0);
        $display("rx 10 done");
    endtask

    initial
    begin
        {rst_i, speed_100_i, squelch_i, line_bit_i, line_bit_en_i} = 5'h18;
        {line_idle_i, false_carrier_i, rx_nib_valid_i} = 3'h0;
        rx_nib_i = '0;
        tick(3);
        rst_i = 1'b0;
        check({crs, rxd, receive_error_pin}, 4'h0);
        tick(1);
        t_tx100();
        t_tx10();
        t_rx100();
        t_drain();
        t_false();
        t_rx10();
        complete_run();
    end
endmodule
